// ---- design/plk_defines.svh ----
// Constants for the bus lock handling block
`ifndef PLK_DEFINES_SVH
`define PLK_DEFINES_SVH

// ----------------------------------------
// Multifunction terminal four routing
// ----------------------------------------
`define PLK_MF4_SEL_W 4
`define PLK_MF4_SEL_LOCK 4'h2

// ----------------------------------------
// Lock granularity and address layout
// ----------------------------------------
`define PLK_ADDR_W 32
`define PLK_LOCK_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PLK_RST_POST_EN 1'b1
`define PLK_RST_PIN_N 1'b1
`define PLK_RST_REGION 28'h0000000
`define PLK_RST_DRIVE 1'h1
`define PLK_RST_OE 1'h0
`define PLK_RST_SEEN 1'h0
`define PLK_RST_OE_HIST 2'h0
`define PLK_RST_INT_N 1'h1

`endif

// ---- design/plk_lock_bridge.sv ----
// Exclusive access handling between the PCI side and the CardBus side
`timescale 1ns/1ns
`include "plk_defines.svh"

module plk_lock_bridge (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [`PLK_MF4_SEL_W-1:0] multifunction_terminal_four_sel,
  input wire logic multifunction_terminal_four,
  input wire plk_pkg::plk_req_t req,
  input wire logic [1:0] int_req,
  input wire logic cardbus_lock_line_i,
  output logic cardbus_lock_line_o,
  output logic cardbus_lock_line_oe,
  output plk_pkg::plk_ans_t ans,
  output logic post_en,
  output logic lock_active,
  output logic cardbus_lock_seen,
  output logic inta_n,
  output logic intb_n
);
  import plk_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic same_block(
    input logic [`PLK_ADDR_W-1:0] addr,
    input logic [`PLK_ADDR_W-`PLK_LOCK_LSB-1:0] region
  );
    same_block = addr[`PLK_ADDR_W-1:`PLK_LOCK_LSB] == region;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic mf4_meta_q;
  logic mf4_sync_q;
  logic cbl_meta_q;
  logic cbl_sync_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mf4_meta_q <= `PLK_RST_PIN_N;
      mf4_sync_q <= `PLK_RST_PIN_N;
      cbl_meta_q <= `PLK_RST_PIN_N;
      cbl_sync_q <= `PLK_RST_PIN_N;
    end else begin
      mf4_meta_q <= multifunction_terminal_four;
      mf4_sync_q <= mf4_meta_q;
      cbl_meta_q <= cardbus_lock_line_i;
      cbl_sync_q <= cbl_meta_q;
    end
  end

  // terminal four routing
  // Other routing codes leave the lock deasserted, so no lock can start
  logic pci_lock_n;
  assign pci_lock_n = (multifunction_terminal_four_sel == `PLK_MF4_SEL_LOCK) ? mf4_sync_q
                                                        : 1'b1;

  // ----------------------------------------
  // Lock state machine
  // ----------------------------------------
  plk_state_t state_q, state_d;
  logic [`PLK_ADDR_W-`PLK_LOCK_LSB-1:0] region_q, region_d;
  plk_ans_t ans_q, ans_d;
  logic post_en_q, post_en_d;
  logic cbl_o_q, cbl_o_d;
  logic cbl_oe_q, cbl_oe_d;
  logic seen_q, seen_d;
  logic [1:0] oe_hist_q, oe_hist_d;
  logic inta_n_q, inta_n_d;
  logic intb_n_q, intb_n_d;

  always_comb begin
    state_d = state_q;
    region_d = region_q;
    ans_d = '0;
    unique case (state_q)
      PLK_IDLE: begin
        ans_d.accept = req.valid;
        // downstream only
        // The initiator's own handshake decides ownership, not the grant
        if (req.valid && req.locked && req.downstream && !pci_lock_n) begin
          state_d = PLK_LOCKED;
          region_d = req.addr[`PLK_ADDR_W-1:`PLK_LOCK_LSB];
        end
      end
      PLK_LOCKED: begin
        if (req.valid) begin
          if (!req.locked && same_block(req.addr, region_q)) begin
            ans_d.retry = 1'b1;
          end else begin
            ans_d.accept = 1'b1;
          end
        end
        if (pci_lock_n) begin
          state_d = PLK_DRAIN;
        end
      end
      PLK_DRAIN: begin
        ans_d.accept = req.valid;
        state_d = PLK_IDLE;
      end
    endcase
    post_en_d = state_d == PLK_IDLE;
    // CardBus lock line
    // Driven high for one cycle before release so it never floats low
    cbl_oe_d = state_d != PLK_IDLE;
    cbl_o_d = state_d != PLK_LOCKED;
    // Line samples lag two cycles, so our own recent drive is masked
    oe_hist_d = {oe_hist_q[0], cbl_oe_q};
    seen_d = !cbl_oe_q && oe_hist_q == 2'h0 && !cbl_sync_q;
    inta_n_d = !int_req[0];
    intb_n_d = !int_req[1];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= PLK_IDLE;
      region_q <= `PLK_RST_REGION;
      ans_q <= '0;
      post_en_q <= `PLK_RST_POST_EN;
      cbl_o_q <= `PLK_RST_DRIVE;
      cbl_oe_q <= `PLK_RST_OE;
      seen_q <= `PLK_RST_SEEN;
      oe_hist_q <= `PLK_RST_OE_HIST;
      inta_n_q <= `PLK_RST_INT_N;
      intb_n_q <= `PLK_RST_INT_N;
    end else begin
      state_q <= state_d;
      region_q <= region_d;
      ans_q <= ans_d;
      post_en_q <= post_en_d;
      cbl_o_q <= cbl_o_d;
      cbl_oe_q <= cbl_oe_d;
      seen_q <= seen_d;
      oe_hist_q <= oe_hist_d;
      inta_n_q <= inta_n_d;
      intb_n_q <= intb_n_d;
    end
  end

  assign ans = ans_q;
  assign post_en = post_en_q;
  assign lock_active = cbl_oe_q;
  assign cardbus_lock_line_o = cbl_o_q;
  assign cardbus_lock_line_oe = cbl_oe_q;
  assign cardbus_lock_seen = seen_q;
  assign inta_n = inta_n_q;
  assign intb_n = intb_n_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb_clk @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_route_gate;
    state_q == PLK_IDLE && multifunction_terminal_four_sel != `PLK_MF4_SEL_LOCK
      |=> state_q == PLK_IDLE;
  endproperty
  a_route_gate: assert property (p_route_gate)
    else $error("lock started without terminal four routing");

  property p_downstream_only;
    state_q == PLK_IDLE && req.valid && !req.downstream
      |=> state_q == PLK_IDLE;
  endproperty
  a_downstream_only: assert property (p_downstream_only)
    else $error("upstream transaction started a lock");

  property p_outside_passes;
    state_q == PLK_LOCKED && req.valid && !req.locked &&
      !same_block(req.addr, region_q) |=> ans_q.accept && !ans_q.retry;
  endproperty
  a_outside_passes: assert property (p_outside_passes)
    else $error("request outside locked block not accepted");

  property p_block_retry;
    state_q == PLK_LOCKED && req.valid && !req.locked &&
      same_block(req.addr, region_q) |=> ans_q.retry && !ans_q.accept;
  endproperty
  a_block_retry: assert property (p_block_retry)
    else $error("request inside locked block not retried");

  property p_no_posting;
    state_q != PLK_IDLE |-> !post_en_q;
  endproperty
  a_no_posting: assert property (p_no_posting)
    else $error("posting enabled during lock");

  property p_cb_drive;
    state_q == PLK_LOCKED |-> cbl_oe_q && !cbl_o_q;
  endproperty
  a_cb_drive: assert property (p_cb_drive)
    else $error("CardBus lock line not driven low while locked");

  property p_cb_release;
    state_q == PLK_LOCKED && pci_lock_n |=> cbl_oe_q && cbl_o_q ##1 !cbl_oe_q;
  endproperty
  a_cb_release: assert property (p_cb_release)
    else $error("CardBus lock line release sequence wrong");

  property p_own_drive_masked;
    cbl_oe_q |=> !seen_q ##1 !seen_q ##1 !seen_q;
  endproperty
  a_own_drive_masked: assert property (p_own_drive_masked)
    else $error("own drive of the CardBus lock line reported as sensed");

  property p_resume;
    state_q == PLK_LOCKED && pci_lock_n |=> !post_en_q ##1 post_en_q;
  endproperty
  a_resume: assert property (p_resume)
    else $error("posting did not resume after release");

  property p_int_out;
    int_req == 2'h3 |=> !inta_n_q && !intb_n_q;
  endproperty
  a_int_out: assert property (p_int_out)
    else $error("interrupt outputs not asserted");

  c_lock_start: cover property (state_q == PLK_IDLE ##1
    state_q == PLK_LOCKED);
  c_retry: cover property (ans_q.retry);
  c_full_cycle: cover property (state_q == PLK_DRAIN ##1
    state_q == PLK_IDLE);

endmodule

// ---- design/plk_pkg.sv ----
// Types for the bus lock handling block
`include "plk_defines.svh"

package plk_pkg;

  // ----------------------------------------
  // Lock state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    PLK_IDLE,
    PLK_LOCKED,
    PLK_DRAIN
  } plk_state_t;

  // ----------------------------------------
  // Decoded transaction from the PCI target side
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [`PLK_ADDR_W-1:0] addr;
    logic write;
    logic downstream;
    logic locked;
  } plk_req_t;

  // ----------------------------------------
  // Answer to a decoded transaction
  // ----------------------------------------
  typedef struct packed {
    logic accept;
    logic retry;
  } plk_ans_t;

endpackage

// ---- testbench/plk_far_model.sv ----
// Far-side model: host lock pin and CardBus card on the lock line
`timescale 1ns/1ns

module plk_far_model (
  input wire logic clock,
  input wire logic host_lock,
  input wire logic card_lock,
  input wire logic drv_o,
  input wire logic drv_oe,
  output logic lock_pin_n,
  output logic line_lvl
);
  // own lock handshake
  // Lock comes from its own pin only, never implied by a bus grant
  always_ff @(posedge clock) begin
    lock_pin_n <= ~host_lock;
  end

  // wired lock line
  // Pull-up holds the line high when no party pulls it low
  assign line_lvl = ~((drv_oe & ~drv_o) | card_lock);
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the bus lock handling block
`timescale 1ns/1ns
`include "plk_defines.svh"

module testbench;
  import plk_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [`PLK_MF4_SEL_W-1:0] multifunction_terminal_four_sel = `PLK_MF4_SEL_LOCK;
  logic host_lock = 1'b0;
  logic card_lock = 1'b0;
  logic pin_n, line_lvl, o, oe, post_en, lock_active, seen, inta_n, intb_n;
  plk_req_t req = '0;
  plk_ans_t ans, a;
  logic [1:0] int_req = 2'h0;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  plk_far_model i_far (.clock(clock), .host_lock(host_lock),
    .card_lock(card_lock), .drv_o(o), .drv_oe(oe), .lock_pin_n(pin_n),
    .line_lvl(line_lvl));

  plk_lock_bridge i_dut (.clock(clock), .sys_rst(sys_rst),
    .multifunction_terminal_four_sel(multifunction_terminal_four_sel), .multifunction_terminal_four(pin_n),
    .req(req), .int_req(int_req), .cardbus_lock_line_i(line_lvl),
    .cardbus_lock_line_o(o), .cardbus_lock_line_oe(oe), .ans(ans),
    .post_en(post_en), .lock_active(lock_active),
    .cardbus_lock_seen(seen), .inta_n(inta_n), .intb_n(intb_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One request; the answer stands only in the cycle after the taking edge
  task automatic send(input logic [31:0] ad, input logic lk,
                      input logic dn, input logic wr = 1'b0);
    @(posedge clock);
    req <= '{1'b1, ad, wr, dn, lk};
    @(posedge clock);
    req.valid <= 1'b0;
    #1 a = ans;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic t_lock;
    @(posedge clock);
    host_lock <= 1'b1;
    wait_cycles(4);
    send(32'h1000_0040, 1'b1, 1'b1);
    chk(32'(a), 32'h2);
    chk(32'({post_en, lock_active, oe, o}), 32'h6);
    send(32'h1000_004c, 1'b0, 1'b1);
    chk(32'(a), 32'h1);
    send(32'h1000_0050, 1'b0, 1'b1);
    chk(32'(a), 32'h2);
    send(32'h1000_003f, 1'b0, 1'b1);
    chk(32'(a), 32'h2);
    chk(32'({oe, o, line_lvl}), 32'h4);
    @(posedge clock);
    host_lock <= 1'b0;
    wait_cycles(4);
    chk(32'({post_en, lock_active, oe, o}), 32'h7);
    wait_cycles(1);
    chk(32'({post_en, lock_active, oe}), 32'h4);
    wait_cycles(1);
    chk(32'(seen), 32'h0);
  endtask

  // Lock held: a second locked request and an unlocked write outside the block are both accepted
  task automatic t_full;
    @(posedge clock);
    host_lock <= 1'b1;
    wait_cycles(4);
    send(32'h3000_0000, 1'b1, 1'b1);
    chk(32'(lock_active), 32'h1);
    send(32'h3000_0008, 1'b1, 1'b1);
    chk(32'(a), 32'h2);
    send(32'h3000_1000, 1'b0, 1'b1, 1'b1);
    chk(32'({a, post_en}), 32'h4);
    @(posedge clock);
    host_lock <= 1'b0;
    wait_cycles(5);
    chk(32'({post_en, lock_active}), 32'h2);
  endtask

  task automatic t_refuse;
    @(posedge clock);
    host_lock <= 1'b1;
    wait_cycles(4);
    send(32'h2000_0000, 1'b1, 1'b0);
    chk(32'({a, lock_active, post_en}), 32'h9);
    @(posedge clock);
    multifunction_terminal_four_sel <= 4'h0;
    wait_cycles(3);
    send(32'h2000_0000, 1'b1, 1'b1);
    chk(32'({a, lock_active, post_en}), 32'h9);
    @(posedge clock);
    host_lock <= 1'b0;
    multifunction_terminal_four_sel <= `PLK_MF4_SEL_LOCK;
    wait_cycles(4);
  endtask

  task automatic t_irq;
    @(posedge clock);
    int_req <= 2'h1;
    wait_cycles(2);
    chk(32'({inta_n, intb_n}), 32'h1);
    @(posedge clock);
    int_req <= 2'h2;
    wait_cycles(2);
    chk(32'({inta_n, intb_n}), 32'h2);
    @(posedge clock);
    int_req <= 2'h3;
    wait_cycles(2);
    chk(32'({inta_n, intb_n}), 32'h0);
    @(posedge clock);
    int_req <= 2'h0;
    wait_cycles(2);
    chk(32'({inta_n, intb_n}), 32'h3);
  endtask

  task automatic t_sense;
    @(posedge clock);
    card_lock <= 1'b1;
    wait_cycles(5);
    chk(32'({seen, oe}), 32'h2);
    @(posedge clock);
    card_lock <= 1'b0;
    wait_cycles(5);
    chk(32'(seen), 32'h0);
  endtask

  task report_and_stop;
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Ceiling well above the roughly 80 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    wait_cycles(1);
    chk(32'({post_en, oe, o, lock_active, seen, inta_n, intb_n}),
        32'h53);
    t_lock();
    t_full();
    t_refuse();
    t_irq();
    t_sense();
    report_and_stop();
  end
endmodule
